//--- lutdac_pkg.sv
// Constants shared by the look-up table and converter control path.
// Assumes byte-wide memory accesses already decoded from the serial link.
package lutdac_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int ROW_W = 6;
  localparam int TABLE_DEPTH = 64;
  localparam int GP_DEPTH = 128;
  localparam int FILTER_MATCHES = 4;
  localparam int CNT_W = 3;

  // Memory map
  localparam logic [8:0] GP_BASE = 9'h000;
  localparam logic [8:0] GP_LAST = 9'h07F;
  localparam logic [8:0] CTRL_BASE = 9'h080;
  localparam logic [8:0] CTRL_LAST = 9'h085;
  localparam logic [8:0] WRITE_ENABLE_CONTROL_ADDR = 9'h086;
  localparam logic [8:0] CONVERTER_RESULT_STATUS_ADDR = 9'h087;
  localparam logic [8:0] TABLE_ONE_BASE = 9'h090;
  localparam logic [8:0] TABLE_ONE_LAST = 9'h0CF;
  localparam logic [8:0] TABLE_TWO_BASE = 9'h0D0;
  localparam logic [8:0] TABLE_TWO_LAST = 9'h10F;
  localparam int CTRL_COUNT = 6;

  // Control register indices
  localparam int CTRL0_IDX = 0;
  localparam int CTRL1_IDX = 1;
  localparam int CTRL2_IDX = 2;
  localparam int CTRL3_IDX = 3;
  localparam int CTRL4_IDX = 4;
  localparam int CTRL5_IDX = 5;

  // Control register 0 field positions
  localparam int REF_SEL_BIT = 0;
  localparam int INPUT_SEL_BIT = 1;
  localparam int DIR_ONE_BIT = 2;
  localparam int DIR_TWO_BIT = 3;
  localparam int FILTER_DIS_BIT = 4;

  // Control register 5 field positions
  localparam int DAC_TWO_DIRECT_BIT = 7;
  localparam int TABLE_TWO_ROW_BIT = 6;
  localparam int DAC_ONE_DIRECT_BIT = 5;
  localparam int TABLE_ONE_ROW_BIT = 4;
  localparam int FS_TWO_LSB = 2;
  localparam int FS_ONE_LSB = 0;

  // Write enable register
  localparam int LATCH_BIT = 7;

  // Slice positions and index widths
  localparam int UPPER_LSB = 2;
  localparam int FS_W = 2;
  localparam int GP_IDX_W = 7;
  localparam int CTRL_IDX_W = 3;

  // Reset values and filter count constants
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [ROW_W-1:0] ROW_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
endpackage : lutdac_pkg

//--- lutdac_control.sv
// Control path of a dual-channel sensor conditioner: write-enable latch,
// converter result filter, two look-up tables and DAC input selection.
// Assumes a serial slave front end that turns bus traffic into single
// cycle byte read/write requests, and a converter giving a done strobe.
//
// Function
// - DAC two direct bit low: DAC two takes table two row byte.
// - DAC two direct bit high: DAC two takes control register 4.
// - Writes other than to 86h abort and are not acknowledged unless write-enable latch set.
// - Write-enable latch is volatile and clears to 0 at reset.
// - Writing 80h to location 86h sets the write-enable latch.
// - Latch stays set until reset or a write to 86h with bit 7 clear, such as 00h.
// - Changing the latch leaves other bits of that register unchanged.
// - Converter result is a read-only status byte at 87h.
// - Status byte is the 8-bit code, 00h minimum to FFh full scale.
// - Upper six result bits index both tables in converter mode.
// - Filter on: update result after four equal upper-six conversions.
// - Filter off: update result after every conversion.
// - Reference select bit: 0 internal and driven out, 1 external.
// - Input select bit: 0 temperature sensor, 1 external sense pin.
// - Two 64-byte tables; each outputs the byte of its selected row.
// - Row byte address is base 90h or D0h plus row index.
// - Direct-row mode takes row from six LSBs of control 1 or 2.
// - Two-bit full-scale field per channel picks range resistor.
// - Two direction bits set source or sink per channel.
// - Table one row select bit: 0 converter, 1 direct row bits.
// - DAC one direct bit: 0 table one row, 1 control register 3.
// - Both DAC bytes held at 00h until first valid result.
// - Table two row select bit: 0 converter, 1 direct row bits.
`timescale 1ns/1ps
`default_nettype none

module lutdac_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Memory access from serial front end
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_done,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // Converter
  input wire logic [7:0] adc_code,
  input wire logic adc_done,
  output logic reference_source_select,
  output logic reference_pin_drive_en,
  output logic converter_input_select,
  // Current channels
  output logic [7:0] dac_one_code,
  output logic [7:0] dac_two_code,
  output logic [8:0] table_one_row_addr,
  output logic [8:0] table_two_row_addr,
  output logic [1:0] channel_one_full_scale_select,
  output logic [1:0] channel_two_full_scale_select,
  output logic channel_one_direction,
  output logic channel_two_direction
);

  // Storage
  logic [7:0] gp_mem [0:lutdac_pkg::GP_DEPTH-1];
  logic [7:0] table_one [0:lutdac_pkg::TABLE_DEPTH-1];
  logic [7:0] table_two [0:lutdac_pkg::TABLE_DEPTH-1];
  logic [7:0] ctrl_reg [0:lutdac_pkg::CTRL_COUNT-1];
  logic [7:0] ctrl_next [0:lutdac_pkg::CTRL_COUNT-1];
  logic write_enable_latch_reg, write_enable_latch_next;

  // Access handshake
  logic mem_done_reg, mem_done_next;
  logic mem_ack_reg, mem_ack_next;
  logic [7:0] mem_rdata_reg, mem_rdata_next;

  // Converter filter
  logic [7:0] result_reg, result_next;
  logic result_valid_reg, result_valid_next;
  logic [5:0] last_upper_reg, last_upper_next;
  logic [2:0] match_cnt_reg, match_cnt_next;

  // DAC inputs
  logic [7:0] dac_one_reg, dac_one_next;
  logic [7:0] dac_two_reg, dac_two_next;

  // Decoded controls
  logic stability_filter_disable;
  logic table_one_direct_row_select, table_two_direct_row_select;
  logic dac_one_direct_select, dac_two_direct_select;
  logic [5:0] row_one, row_two;
  logic [7:0] table_one_byte, table_two_byte;
  logic in_gp, in_ctrl, in_t1, in_t2;
  logic is_latch_loc, is_status;
  logic write_ok;
  logic [8:0] gp_off, ctrl_off, t1_off, t2_off;
  // Narrowed offsets; the range decode keeps each one in bounds
  logic [lutdac_pkg::GP_IDX_W-1:0] gp_idx;
  logic [lutdac_pkg::CTRL_IDX_W-1:0] ctrl_idx;
  logic [lutdac_pkg::ROW_W-1:0] t1_idx, t2_idx;
  logic [lutdac_pkg::ROW_W-1:0] adc_upper, result_upper;
  logic [7:0] latch_byte;

  assign stability_filter_disable =
    ctrl_reg[lutdac_pkg::CTRL0_IDX][lutdac_pkg::FILTER_DIS_BIT];
  assign table_one_direct_row_select =
    ctrl_reg[lutdac_pkg::CTRL5_IDX][lutdac_pkg::TABLE_ONE_ROW_BIT];
  assign table_two_direct_row_select =
    ctrl_reg[lutdac_pkg::CTRL5_IDX][lutdac_pkg::TABLE_TWO_ROW_BIT];
  assign dac_one_direct_select =
    ctrl_reg[lutdac_pkg::CTRL5_IDX][lutdac_pkg::DAC_ONE_DIRECT_BIT];
  assign dac_two_direct_select =
    ctrl_reg[lutdac_pkg::CTRL5_IDX][lutdac_pkg::DAC_TWO_DIRECT_BIT];

  // Row selection, converter or direct bits
  assign adc_upper =
    adc_code[lutdac_pkg::UPPER_LSB +: lutdac_pkg::ROW_W];
  assign result_upper =
    result_reg[lutdac_pkg::UPPER_LSB +: lutdac_pkg::ROW_W];
  assign row_one = table_one_direct_row_select ?
    ctrl_reg[lutdac_pkg::CTRL1_IDX][lutdac_pkg::ROW_W-1:0] :
    result_upper;
  assign row_two = table_two_direct_row_select ?
    ctrl_reg[lutdac_pkg::CTRL2_IDX][lutdac_pkg::ROW_W-1:0] :
    result_upper;
  assign table_one_byte = table_one[row_one];
  assign table_two_byte = table_two[row_two];

  // Address decode
  assign in_gp = (mem_addr <= lutdac_pkg::GP_LAST);
  assign in_ctrl = (mem_addr >= lutdac_pkg::CTRL_BASE) &&
                   (mem_addr <= lutdac_pkg::CTRL_LAST);
  assign in_t1 = (mem_addr >= lutdac_pkg::TABLE_ONE_BASE) &&
                 (mem_addr <= lutdac_pkg::TABLE_ONE_LAST);
  assign in_t2 = (mem_addr >= lutdac_pkg::TABLE_TWO_BASE) &&
                 (mem_addr <= lutdac_pkg::TABLE_TWO_LAST);
  assign is_latch_loc = (mem_addr == lutdac_pkg::WRITE_ENABLE_CONTROL_ADDR);
  assign is_status = (mem_addr == lutdac_pkg::CONVERTER_RESULT_STATUS_ADDR);
  assign gp_off = mem_addr - lutdac_pkg::GP_BASE;
  assign ctrl_off = mem_addr - lutdac_pkg::CTRL_BASE;
  assign t1_off = mem_addr - lutdac_pkg::TABLE_ONE_BASE;
  assign t2_off = mem_addr - lutdac_pkg::TABLE_TWO_BASE;
  assign gp_idx = gp_off[lutdac_pkg::GP_IDX_W-1:0];
  assign ctrl_idx = ctrl_off[lutdac_pkg::CTRL_IDX_W-1:0];
  assign t1_idx = t1_off[lutdac_pkg::ROW_W-1:0];
  assign t2_idx = t2_off[lutdac_pkg::ROW_W-1:0];

  // Latch register itself is always writable, everything else needs it
  assign write_ok =
    mem_wr && (write_enable_latch_reg || is_latch_loc);

  // Reserved bits of the latch location read back as zero
  always_comb begin
    latch_byte = lutdac_pkg::BYTE_ZERO;
    latch_byte[lutdac_pkg::LATCH_BIT] = write_enable_latch_reg;
  end

  // Control registers and latch
  always_comb begin
    for (int i = 0; i < lutdac_pkg::CTRL_COUNT; i++) begin
      ctrl_next[i] = ctrl_reg[i];
    end
    write_enable_latch_next = write_enable_latch_reg;
    if (write_ok && in_ctrl) begin
      ctrl_next[ctrl_idx] = mem_wdata;
    end
    // Reserved bits of this register hold nothing, so only the latch moves
    if (write_ok && is_latch_loc) begin
      write_enable_latch_next =
        mem_wdata[lutdac_pkg::LATCH_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < lutdac_pkg::CTRL_COUNT; i++) begin
        ctrl_reg[i] <= lutdac_pkg::CTRL_RESET;
      end
      write_enable_latch_reg <= 1'b0;
    end else begin
      for (int i = 0; i < lutdac_pkg::CTRL_COUNT; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
      end
      write_enable_latch_reg <= write_enable_latch_next;
    end
  end

  // Arrays: written in place to keep them as plain memories
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < lutdac_pkg::GP_DEPTH; i++) begin
        gp_mem[i] <= lutdac_pkg::BYTE_ZERO;
      end
      for (int i = 0; i < lutdac_pkg::TABLE_DEPTH; i++) begin
        table_one[i] <= lutdac_pkg::BYTE_ZERO;
        table_two[i] <= lutdac_pkg::BYTE_ZERO;
      end
    end else if (write_ok) begin
      if (in_gp) begin
        gp_mem[gp_idx] <= mem_wdata;
      end
      if (in_t1) begin
        table_one[t1_idx] <= mem_wdata;
      end
      if (in_t2) begin
        table_two[t2_idx] <= mem_wdata;
      end
    end
  end

  // Access answer
  always_comb begin
    mem_done_next = mem_wr || mem_rd;
    mem_ack_next = 1'b0;
    mem_rdata_next = mem_rdata_reg;
    if (mem_wr) begin
      mem_ack_next = write_ok;
    end else if (mem_rd) begin
      mem_ack_next = 1'b1;
      mem_rdata_next = lutdac_pkg::BYTE_ZERO;
      if (in_gp) begin
        mem_rdata_next = gp_mem[gp_idx];
      end else if (in_ctrl) begin
        mem_rdata_next = ctrl_reg[ctrl_idx];
      end else if (is_latch_loc) begin
        mem_rdata_next = latch_byte;
      end else if (is_status) begin
        mem_rdata_next = result_reg;
      end else if (in_t1) begin
        mem_rdata_next = table_one[t1_idx];
      end else if (in_t2) begin
        mem_rdata_next = table_two[t2_idx];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_done_reg <= 1'b0;
      mem_ack_reg <= 1'b0;
      mem_rdata_reg <= lutdac_pkg::BYTE_ZERO;
    end else begin
      mem_done_reg <= mem_done_next;
      mem_ack_reg <= mem_ack_next;
      mem_rdata_reg <= mem_rdata_next;
    end
  end

  // Stability filter; a noisy sensor near a row edge would otherwise
  // make the tables chatter between neighbouring rows
  always_comb begin
    result_next = result_reg;
    result_valid_next = result_valid_reg;
    last_upper_next = last_upper_reg;
    match_cnt_next = match_cnt_reg;
    if (adc_done) begin
      last_upper_next = adc_upper;
      // Saturating count: a steady input reloads the result every time
      if (match_cnt_reg == lutdac_pkg::CNT_ZERO ||
          adc_upper != last_upper_reg) begin
        match_cnt_next = lutdac_pkg::CNT_ONE;
      end else if (match_cnt_reg != lutdac_pkg::CNT_FULL) begin
        match_cnt_next = match_cnt_reg + lutdac_pkg::CNT_ONE;
      end
      if (stability_filter_disable) begin
        result_next = adc_code;
        result_valid_next = 1'b1;
      end else if (match_cnt_next == lutdac_pkg::CNT_FULL) begin
        result_next = adc_code;
        result_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_reg <= lutdac_pkg::BYTE_ZERO;
      result_valid_reg <= 1'b0;
      last_upper_reg <= lutdac_pkg::ROW_ZERO;
      match_cnt_reg <= lutdac_pkg::CNT_ZERO;
    end else begin
      result_reg <= result_next;
      result_valid_reg <= result_valid_next;
      last_upper_reg <= last_upper_next;
      match_cnt_reg <= match_cnt_next;
    end
  end

  // DAC input selection
  always_comb begin
    dac_one_next = lutdac_pkg::BYTE_ZERO;
    dac_two_next = lutdac_pkg::BYTE_ZERO;
    // Direct bytes also wait for the first result, as after power-up
    if (result_valid_reg) begin
      if (dac_one_direct_select) begin
        dac_one_next = ctrl_reg[lutdac_pkg::CTRL3_IDX];
      end else begin
        dac_one_next = table_one_byte;
      end
      if (dac_two_direct_select) begin
        dac_two_next = ctrl_reg[lutdac_pkg::CTRL4_IDX];
      end else begin
        dac_two_next = table_two_byte;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dac_one_reg <= lutdac_pkg::BYTE_ZERO;
      dac_two_reg <= lutdac_pkg::BYTE_ZERO;
    end else begin
      dac_one_reg <= dac_one_next;
      dac_two_reg <= dac_two_next;
    end
  end

  // Outputs
  assign mem_done = mem_done_reg;
  assign mem_ack = mem_ack_reg;
  assign mem_rdata = mem_rdata_reg;
  assign dac_one_code = dac_one_reg;
  assign dac_two_code = dac_two_reg;
  assign table_one_row_addr =
    lutdac_pkg::TABLE_ONE_BASE + {3'h0, row_one};
  assign table_two_row_addr =
    lutdac_pkg::TABLE_TWO_BASE + {3'h0, row_two};
  assign reference_source_select =
    ctrl_reg[lutdac_pkg::CTRL0_IDX][lutdac_pkg::REF_SEL_BIT];
  assign reference_pin_drive_en = !reference_source_select;
  assign converter_input_select =
    ctrl_reg[lutdac_pkg::CTRL0_IDX][lutdac_pkg::INPUT_SEL_BIT];
  assign channel_one_direction =
    ctrl_reg[lutdac_pkg::CTRL0_IDX][lutdac_pkg::DIR_ONE_BIT];
  assign channel_two_direction =
    ctrl_reg[lutdac_pkg::CTRL0_IDX][lutdac_pkg::DIR_TWO_BIT];
  assign channel_one_full_scale_select =
    ctrl_reg[lutdac_pkg::CTRL5_IDX]
      [lutdac_pkg::FS_ONE_LSB +: lutdac_pkg::FS_W];
  assign channel_two_full_scale_select =
    ctrl_reg[lutdac_pkg::CTRL5_IDX]
      [lutdac_pkg::FS_TWO_LSB +: lutdac_pkg::FS_W];

endmodule : lutdac_control

`default_nettype wire

//--- lutdac_control_sva.sv
// Checker on control path ports: latch, status reads, row range, DAC hold.
// Assumes it is bound to lutdac_control, single clock ref_clk.
`timescale 1ns/1ps
`default_nettype none
module lutdac_control_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Memory port
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_done,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // Converter and outputs
  input wire logic [7:0] adc_code,
  input wire logic adc_done,
  input wire logic reference_source_select,
  input wire logic reference_pin_drive_en,
  input wire logic [7:0] dac_one_code,
  input wire logic [7:0] dac_two_code,
  input wire logic [8:0] table_one_row_addr,
  input wire logic [8:0] table_two_row_addr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic latch_reg, latch_next, raw_reg, raw_next, rd_ok;
  logic ref_reg, ref_next;
  logic [1:0] rows_reg, rows_next;
  assign rd_ok = mem_rd && !mem_wr;
  // Mirror of latch, control 0 bits and row-select bits, from port traffic
  always_comb begin
    latch_next = latch_reg;
    raw_next = raw_reg;
    ref_next = ref_reg;
    rows_next = rows_reg;
    if (mem_wr && mem_addr == 9'h086) latch_next = mem_wdata[7];
    if (mem_wr && mem_addr == 9'h080 && latch_reg) begin
      raw_next = mem_wdata[4];
      ref_next = mem_wdata[0];
    end
    if (mem_wr && mem_addr == 9'h085 && latch_reg) begin
      rows_next = {mem_wdata[6], mem_wdata[4]};
    end
  end
  always_ff @(posedge ref_clk) begin
    latch_reg <= rst_n && latch_next;
    raw_reg <= rst_n && raw_next;
    ref_reg <= rst_n && ref_next;
    rows_reg <= rst_n ? rows_next : 2'h0;
  end
  sequence quiet_s;
    (!adc_done && !mem_wr) [*4];
  endsequence
  sequence raw_read_s;
    adc_done && raw_reg ##1 !adc_done
      ##1 rd_ok && !adc_done && mem_addr == 9'h087;
  endsequence
  wr_abort_a: assert property (
    mem_wr && mem_addr != 9'h086 && !latch_reg |=> mem_done && !mem_ack)
    else $error("locked write was accepted");
  latch_read_a: assert property (
    rd_ok && mem_addr == 9'h086 |=> mem_rdata == {$past(latch_reg), 7'h00})
    else $error("latch readback wrong");
  status_read_a: assert property (
    rd_ok && mem_addr == 9'h087 |=> mem_done && mem_ack)
    else $error("status read not answered");
  ref_pin_a: assert property (
    reference_source_select == ref_reg &&
      reference_pin_drive_en == !ref_reg)
    else $error("reference select or pin drive wrong");
  row_one_a: assert property (
    table_one_row_addr inside {[9'h090:9'h0CF]})
    else $error("table one row out of range");
  row_two_a: assert property (
    table_two_row_addr inside {[9'h0D0:9'h10F]})
    else $error("table two row out of range");
  row_pair_a: assert property (
    rows_reg == 2'h0 |->
      table_two_row_addr - table_one_row_addr == 9'h040)
    else $error("tables not on the same converter row");
  dac_hold_a: assert property (
    quiet_s |=> $stable(dac_one_code) && $stable(dac_two_code))
    else $error("DAC byte moved without cause");
  raw_read_a: assert property (
    raw_read_s |=> mem_rdata == $past(adc_code, 3))
    else $error("unfiltered result not stored");
endmodule : lutdac_control_sva
bind lutdac_control lutdac_control_sva CHK (.ref_clk, .rst_n, .mem_wr,
  .mem_rd, .mem_addr, .mem_wdata, .mem_done, .mem_ack, .mem_rdata,
  .adc_code, .adc_done, .reference_source_select, .reference_pin_drive_en,
  .dac_one_code, .dac_two_code, .table_one_row_addr, .table_two_row_addr);
`default_nettype wire

//--- lutdac_master_model.sv
// Stand-in for the serial bus master: single byte requests.
// Assumes a request is taken at the edge after it is driven.
`timescale 1ns/1ps
`default_nettype none
module lutdac_master_model (
  // Clock
  input wire logic ref_clk,
  // Requests
  output logic mem_wr,
  output logic mem_rd,
  output logic [8:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Answers
  input wire logic mem_done,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  initial begin
    {mem_wr, mem_rd, mem_addr, mem_wdata} = 19'h1FFFF;
  end
  task automatic access(input logic w, input logic [8:0] a,
      input logic [7:0] d, output logic ack, output logic [7:0] q,
      output logic hung);
    int n;
    @(posedge ref_clk);
    #10;
    {mem_wr, mem_rd, mem_addr, mem_wdata} = {w, !w, a, d};
    @(posedge ref_clk);
    #10;
    // Idle lines carry the inverse, so a stale value never looks valid
    {mem_wr, mem_rd, mem_addr, mem_wdata} = {2'b00, ~a, ~d};
    for (n = 0; n < 8 && mem_done !== 1'b1; n++) begin
      @(posedge ref_clk);
      #10;
    end
    {hung, ack, q} = {mem_done !== 1'b1, mem_ack, mem_rdata};
  endtask : access
  task automatic set_latch(input logic en, output logic ack,
      output logic hung);
    logic [7:0] q;
    access(1'b1, 9'h086, {en, 7'h00}, ack, q, hung);
  endtask : set_latch
endmodule : lutdac_master_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the control path through its memory port.
// Assumes the master model makes requests; the bench drives the ADC.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, rst_n, mem_wr, mem_rd, mem_done, mem_ack, adc_done;
  logic ref_sel, pin_en, in_sel, dir1, dir2, ack, hung;
  logic [1:0] fs1, fs2;
  logic [7:0] mem_wdata, mem_rdata, adc_code, dac1, dac2, q;
  logic [8:0] mem_addr, row1, row2;
  logic [7:0] codes [7] = '{8'h14, 8'h14, 8'h14, 8'h18, 8'h14, 8'h14, 8'h14};
  int bad_count = 0;
  int check_count = 0;
  lutdac_control DUT (.ref_clk, .rst_n, .mem_wr, .mem_rd, .mem_addr,
    .mem_wdata, .mem_done, .mem_ack, .mem_rdata, .adc_code, .adc_done,
    .reference_source_select(ref_sel), .reference_pin_drive_en(pin_en),
    .converter_input_select(in_sel), .dac_one_code(dac1),
    .dac_two_code(dac2), .table_one_row_addr(row1),
    .table_two_row_addr(row2), .channel_one_full_scale_select(fs1),
    .channel_two_full_scale_select(fs2), .channel_one_direction(dir1),
    .channel_two_direction(dir2));
  lutdac_master_model M (.ref_clk, .mem_wr, .mem_rd, .mem_addr, .mem_wdata,
    .mem_done, .mem_ack, .mem_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // A request that never completes ends the run
  task automatic guard();
    if (hung !== 1'b0) begin
      bad_count++;
      print_verdict();
    end
  endtask : guard
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    M.access(1'b0, a, 8'h00, ack, q, hung);
    guard();
    check({1'b0, q}, {1'b0, e});
  endtask : rdc
  task automatic wrc(input logic [8:0] a, input logic [7:0] d, input logic e);
    M.access(1'b1, a, d, ack, q, hung);
    guard();
    check({8'h00, ack}, {8'h00, e});
  endtask : wrc
  task automatic strobe(input logic [7:0] c);
    @(posedge ref_clk);
    #10;
    {adc_code, adc_done} = {c, 1'b1};
    @(posedge ref_clk);
    #10;
    adc_done = 1'b0;
  endtask : strobe
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #10;
  endtask : settle
  initial begin
    {rst_n, adc_done, adc_code} = 10'h000;
    repeat (16) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    check({8'h00, pin_en}, 9'h001);
    check(row1, 9'h090);
    rdc(9'h086, 8'h00);
    wrc(9'h080, 8'h1F, 1'b0);
    rdc(9'h080, 8'h00);
    M.set_latch(1'b1, ack, hung);
    guard();
    check({8'h00, ack}, 9'h001);
    rdc(9'h086, 8'h80);
    wrc(9'h080, 8'h0F, 1'b1);
    check({5'h00, dir2, dir1, in_sel, ref_sel}, 9'h00F);
    check({8'h00, pin_en}, 9'h000);
    for (int i = 0; i < 4; i++) begin
      wrc(9'h085, 8'(i * 3 + 3), 1'b1);
      check({5'h00, fs2, fs1}, 9'(i * 3 + 3));
    end
    wrc(9'h080, 8'h00, 1'b1);
    wrc(9'h095, 8'hA5, 1'b1);
    wrc(9'h0D5, 8'h5A, 1'b1);
    wrc(9'h096, 8'h66, 1'b1);
    wrc(9'h0D6, 8'h99, 1'b1);
    foreach (codes[i]) strobe(codes[i]);
    rdc(9'h087, 8'h00);
    check({1'b0, dac1 | dac2}, 9'h000);
    strobe(8'h17);
    rdc(9'h087, 8'h17);
    check(row1, 9'h095);
    check(row2, 9'h0D5);
    check({dac1, 1'b0}, 9'h14A);
    check({1'b0, dac2}, 9'h05A);
    adc_code = 8'hFC;
    rdc(9'h087, 8'h17);
    wrc(9'h081, 8'hC6, 1'b1);
    wrc(9'h082, 8'h06, 1'b1);
    wrc(9'h083, 8'h33, 1'b1);
    wrc(9'h084, 8'h44, 1'b1);
    wrc(9'h085, 8'h50, 1'b1);
    settle();
    check(row1, 9'h096);
    check(row2, 9'h0D6);
    check({dac1, dac2[0]}, 9'h0CD);
    wrc(9'h085, 8'hF0, 1'b1);
    settle();
    check({1'b0, dac1}, 9'h033);
    check({1'b0, dac2}, 9'h044);
    wrc(9'h080, 8'h10, 1'b1);
    strobe(8'hFF);
    rdc(9'h087, 8'hFF);
    wrc(9'h085, 8'h00, 1'b1);
    settle();
    check(row1, 9'h0CF);
    check(row2, 9'h10F);
    wrc(9'h087, 8'h00, 1'b1);
    rdc(9'h087, 8'hFF);
    M.set_latch(1'b0, ack, hung);
    guard();
    check({8'h00, ack}, 9'h001);
    rdc(9'h086, 8'h00);
    wrc(9'h080, 8'h00, 1'b0);
    strobe(8'h40);
    rdc(9'h087, 8'h40);
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    rdc(9'h087, 8'h00);
    check({1'b0, dac1 | dac2}, 9'h000);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
